//--- rtl/xjic_top.sv
// Overview of operation
// RL1: load package at start, store at end
// RL2: every exchange moves sixteen words
// RL3: exit without exit-monitor uses normal exit address
// RL4: exit with exit-monitor uses j plus K plus base
// RL5: error instruction or enabled error exits
// RL6: arithmetic errors exit only when mode bit set
// RL7: hardware and range errors always exit
// RL8: status word swapped with each package
// RL9: io monitor raises requests on thresholds, records
// RL10: counter advances every clock period
// RL11: 17-bit counter, overflow sets 18th bit
// RL12: real-time flag exchanges to relocatable 0020
// RL13: step mode exits after every instruction word
// RL14: monitor mode holds off interrupts until clear
// RL15: software sets monitor flag in io packages
// RL16: deadstart raises channel 0 request, exchanges
// RL17: deadstart swaps locations 0 through 17
// RL18: deadstart store clears monitor, sets range
// RL19: six program counter copies always equal
// RL20: request flag with 00 blocks range flag; code does not block it in monitor mode
// RL21: priority error, io, real-time, step
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "xjic_regs.svh"
module xjic_top
  import xjic_pkg::*;
#(
  parameter int AW = `XJIC_ADDR_W,
  parameter int DW = 60,
  parameter int NCH = 16
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  // instruction events from the issue logic, one-cycle pulses
  input wire logic exit_instr_i,
  input wire logic [AW-1:0] exit_j_plus_k_i,
  input wire logic err_instr_i,
  input wire logic word_end_i,
  input wire logic ovf_i,
  input wire logic unf_i,
  input wire logic ind_i,
  input wire logic hw_err_i,
  input wire logic range_err_i,
  // io monitor unit events, one bit per channel
  input wire logic [NCH-1:0] buf_thresh_i,
  input wire logic [NCH-1:0] record_pulse_i,
  input wire logic pp_xchg_req_i,
  input wire logic [AW-1:0] buffer_bias_i,
  input wire logic [AW-1:0] mem_base_i,
  // register context, word index selects package slot
  input wire logic [DW-1:0] ctx_rdata_i,
  // central store port
  input wire logic mem_ack_i,
  input wire logic [DW-1:0] mem_rdata_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [AW-1:0] mem_addr_o,
  output logic [DW-1:0] mem_wdata_o,
  output logic [3:0] ctx_idx_o,
  output logic ctx_we_o,
  output logic [DW-1:0] ctx_wdata_o,
  output logic busy_o,
  output logic [AW-1:0] psw_o,
  output logic [AW-1:0] pc_copies_o [6],
  output logic [`XJIC_CNT_W:0] rtc_o
);
  typedef struct packed {
    xjic_state_t st;
    logic [AW-1:0] base;
    logic [4:0] idx;
    logic wr_phase;
    logic ds;
    logic [AW-1:0] psw;
    logic [AW-1:0] normal_exit_address;
    logic [AW-1:0] eea;
    logic [AW-1:0] pc;
    logic [NCH-1:0] io_req;
    logic request_interrupt_flag;
    logic err_pend;
    logic step_pend;
    logic exit_pend;
    logic [AW-1:0] exit_addr;
    logic mreq;
    logic mwe;
    logic [AW-1:0] maddr;
    logic [DW-1:0] mwdata;
    logic cwe;
    logic [DW-1:0] cwdata;
    logic rtc_clr;
    logic busy;
  } xjic_st_t;
  xjic_st_t s_r;
  xjic_st_t s_nxt;
  logic [`XJIC_CNT_W:0] rtc_w;
  logic ds_m_r;
  logic ds_r;
  logic [AW-1:0] word_w;
  logic err_now;

  xjic_rtc #(
    .CNT_W(`XJIC_CNT_W)
  ) u_rtc (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clr_flag_i(s_r.rtc_clr),
    .value_o(rtc_w)
  );

  // enabled error decode, shared by exit request and status capture
  function automatic logic err_hit(input logic [AW-1:0] psw,
                                   input logic o, input logic u,
                                   input logic i, input logic h,
                                   input logic r);
    err_hit = (o & psw[`XJIC_PSW_OVF_MODE]) // RL6
            | (u & psw[`XJIC_PSW_UNF_MODE])
            | (i & psw[`XJIC_PSW_IND_MODE])
            | h | r; // RL7
  endfunction : err_hit

  // deadstart release marker: brought in through two flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ds_m_r <= 1'b0;
      ds_r <= 1'b0;
    end
    else
    begin
      ds_m_r <= 1'b1;
      ds_r <= ds_m_r;
    end
  end

  assign err_now = err_hit(s_r.psw, ovf_i, unf_i, ind_i, hw_err_i,
                           range_err_i);
  // word being stored; deadstart adjusts the status word on its way out
  always_comb
  begin
    word_w = s_r.psw;
    if (s_r.ds)
    begin
      word_w[`XJIC_PSW_MONITOR] = 1'b0; // RL18
      word_w[`XJIC_PSW_RANGE] = 1'b1; // RL18
    end
  end

  // main sequencer
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.mreq = 1'b0;
    s_nxt.mwe = 1'b0;
    s_nxt.cwe = 1'b0;
    s_nxt.rtc_clr = 1'b0;
    // io monitor requests accumulate per channel
    s_nxt.io_req = s_r.io_req | buf_thresh_i | record_pulse_i; // RL9
    if (pp_xchg_req_i)
    begin
      s_nxt.io_req[0] = 1'b1; // RL9
    end
    case (s_r.st)
      XJ_IDLE:
      begin
        // deadstart: channel 0 request, exchange from 0..17
        if (ds_r)
        begin
          s_nxt.io_req = '0;
          s_nxt.io_req[0] = 1'b1; // RL16
          s_nxt.ds = 1'b1;
          s_nxt.base = `XJIC_DS_ADDR + buffer_bias_i; // RL17
          s_nxt.idx = '0;
          s_nxt.wr_phase = 1'b0;
          s_nxt.st = XJ_SWAP;
        end
      end
      XJ_RUN:
      begin
        if (word_end_i)
        begin
          s_nxt.pc = s_r.pc + 1'b1;
        end
        if (err_instr_i)
        begin
          // request flag already set from an earlier cycle blocks the range flag, except in monitor mode
          if (!(|s_r.io_req) || s_r.psw[`XJIC_PSW_MONITOR])
          begin
            s_nxt.psw[`XJIC_PSW_RANGE] = 1'b1; // RL20
            s_nxt.err_pend = 1'b1; // RL5
          end
          else
          begin
            s_nxt.request_interrupt_flag = 1'b1; // RL20
          end
        end
        if (err_now)
        begin
          s_nxt.err_pend = 1'b1; // RL5
          s_nxt.psw[`XJIC_PSW_OVF] = ovf_i | s_r.psw[`XJIC_PSW_OVF]; // RL8
          s_nxt.psw[`XJIC_PSW_UNF] = unf_i | s_r.psw[`XJIC_PSW_UNF];
          s_nxt.psw[`XJIC_PSW_IND] = ind_i | s_r.psw[`XJIC_PSW_IND];
          s_nxt.psw[`XJIC_PSW_HWERR] = hw_err_i
                                     | s_r.psw[`XJIC_PSW_HWERR];
          s_nxt.psw[`XJIC_PSW_RANGE] = range_err_i
                                     | s_r.psw[`XJIC_PSW_RANGE];
        end
        if (word_end_i && s_r.psw[`XJIC_PSW_STEP])
        begin
          s_nxt.step_pend = 1'b1; // RL13
        end
        if (exit_instr_i)
        begin
          s_nxt.exit_pend = 1'b1;
          if (s_r.psw[`XJIC_PSW_EXIT_MON])
          begin
            s_nxt.exit_addr = exit_j_plus_k_i + mem_base_i; // RL4
          end
          else
          begin
            s_nxt.exit_addr = s_r.normal_exit_address; // RL3
          end
        end
        // fixed priority, monitor mode masks interrupts
        s_nxt.idx = '0;
        s_nxt.wr_phase = 1'b0;
        if (s_r.err_pend)
        begin
          s_nxt.base = s_r.eea; // RL21
          s_nxt.err_pend = 1'b0;
          s_nxt.st = XJ_SWAP;
        end
        else if (|s_r.io_req && !s_r.psw[`XJIC_PSW_MONITOR])
        begin
          s_nxt.base = s_r.normal_exit_address; // RL14
          s_nxt.request_interrupt_flag = 1'b0;
          s_nxt.st = XJ_SWAP;
        end
        else if (rtc_w[`XJIC_CNT_W] && !s_r.psw[`XJIC_PSW_MONITOR])
        begin
          s_nxt.base = `XJIC_RTC_ADDR + buffer_bias_i; // RL12
          s_nxt.rtc_clr = 1'b1;
          s_nxt.st = XJ_SWAP;
        end
        else if (s_r.step_pend)
        begin
          s_nxt.base = s_r.eea; // RL13
          s_nxt.step_pend = 1'b0;
          s_nxt.st = XJ_SWAP;
        end
        else if (s_r.exit_pend)
        begin
          s_nxt.base = s_r.exit_addr;
          s_nxt.exit_pend = 1'b0;
          s_nxt.st = XJ_SWAP;
        end
        // causes left from the old context must not fire on the new one
        if (s_nxt.st == XJ_SWAP)
        begin
          s_nxt.err_pend = 1'b0;
          s_nxt.step_pend = 1'b0;
          s_nxt.exit_pend = 1'b0;
        end
      end
      XJ_SWAP:
      begin
        // per word: load new word, then store old one in its place;
        // old word is captured first so the load cannot clobber it
        s_nxt.mreq = 1'b1;
        s_nxt.maddr = s_r.base + AW'(s_r.idx); // RL2
        s_nxt.mwe = s_r.wr_phase; // RL1
        if (!s_r.wr_phase)
        begin
          case (s_r.idx[3:0])
            `XJIC_OFF_P: s_nxt.mwdata = DW'(s_r.pc);
            `XJIC_OFF_PSW: s_nxt.mwdata = DW'(word_w); // RL8
            `XJIC_OFF_NEA: s_nxt.mwdata = DW'(s_r.normal_exit_address);
            `XJIC_OFF_EEA: s_nxt.mwdata = DW'(s_r.eea);
            default: s_nxt.mwdata = ctx_rdata_i;
          endcase
        end
        s_nxt.st = XJ_WAIT;
      end
      XJ_WAIT:
      begin
        if (mem_ack_i)
        begin
          if (!s_r.wr_phase)
          begin
            // load phase: new context enters the registers
            s_nxt.cwe = 1'b1; // RL1
            s_nxt.cwdata = mem_rdata_i;
            case (s_r.idx[3:0])
              `XJIC_OFF_P: s_nxt.pc = mem_rdata_i[AW-1:0];
              `XJIC_OFF_PSW: s_nxt.psw = mem_rdata_i[AW-1:0]; // RL8
              `XJIC_OFF_NEA: s_nxt.normal_exit_address = mem_rdata_i[AW-1:0];
              `XJIC_OFF_EEA: s_nxt.eea = mem_rdata_i[AW-1:0];
              default: s_nxt.cwe = 1'b1;
            endcase
            s_nxt.wr_phase = 1'b1;
            s_nxt.st = XJ_SWAP;
          end
          else
          begin
            s_nxt.wr_phase = 1'b0;
            s_nxt.idx = s_r.idx + 5'd1;
            if (s_r.idx + 5'd1 == `XJIC_PKG_WORDS)
            begin
              s_nxt.st = XJ_RUN; // RL2
              s_nxt.ds = 1'b0;
              if (s_r.ds)
              begin
                s_nxt.io_req[0] = 1'b0;
              end
            end
            else
            begin
              s_nxt.st = XJ_SWAP;
            end
          end
        end
        else
        begin
          s_nxt.mreq = 1'b1; // hold request until accepted
          s_nxt.mwe = s_r.mwe;
        end
      end
      default:
      begin
        s_nxt.st = XJ_IDLE;
      end
    endcase
    // busy registered so the output comes straight from a flop
    s_nxt.busy = (s_nxt.st != XJ_RUN);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
      s_r.st <= XJ_IDLE;
      s_r.psw <= `XJIC_PSW_RESET;
      s_r.busy <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // all six counter copies come from one flop, so they cannot diverge
  generate
    for (genvar g = 0; g < 6; g++)
    begin : g_pc
      assign pc_copies_o[g] = s_r.pc; // RL19
    end
  endgenerate

  assign mem_req_o = s_r.mreq;
  assign mem_we_o = s_r.mwe;
  assign mem_addr_o = s_r.maddr;
  assign mem_wdata_o = s_r.mwdata;
  assign ctx_idx_o = s_r.idx[3:0];
  assign ctx_we_o = s_r.cwe;
  assign ctx_wdata_o = s_r.cwdata;
  assign busy_o = s_r.busy;
  assign psw_o = s_r.psw;
  assign rtc_o = rtc_w;
endmodule : xjic_top

//--- rtl/xjic_regs.svh
`ifndef XJIC_REGS_SVH
`define XJIC_REGS_SVH
// exchange package geometry
`define XJIC_PKG_WORDS 5'd16
`define XJIC_ADDR_W 18
// word offsets inside a package
`define XJIC_OFF_P 4'h0
`define XJIC_OFF_PSW 4'h1
`define XJIC_OFF_NEA 4'h2
`define XJIC_OFF_EEA 4'h3
// fixed package addresses
`define XJIC_RTC_ADDR 18'h00010
`define XJIC_DS_ADDR 18'h00000
// status word field positions
`define XJIC_PSW_EXIT_MON 0
`define XJIC_PSW_MONITOR 1
`define XJIC_PSW_STEP 2
`define XJIC_PSW_OVF_MODE 3
`define XJIC_PSW_UNF_MODE 4
`define XJIC_PSW_IND_MODE 5
`define XJIC_PSW_RANGE 6
`define XJIC_PSW_OVF 7
`define XJIC_PSW_UNF 8
`define XJIC_PSW_IND 9
`define XJIC_PSW_HWERR 10
`define XJIC_PSW_RESET 18'h00000
// clock-period counter
`define XJIC_CNT_W 17
`endif

//--- rtl/xjic_pkg.sv
package xjic_pkg;
  typedef enum logic [2:0] {
    XJ_IDLE,
    XJ_RUN,
    XJ_SWAP,
    XJ_WAIT
  } xjic_state_t;
  typedef enum logic [2:0] {
    XC_NONE,
    XC_ERR,
    XC_IO,
    XC_RTC,
    XC_STEP,
    XC_EXIT
  } xjic_cause_t;
endpackage : xjic_pkg

//--- rtl/xjic_rtc.sv
`timescale 1ns/1ns
`include "xjic_regs.svh"
// free-running clock-period counter with sticky overflow flag
module xjic_rtc
  import xjic_pkg::*;
#(
  parameter int CNT_W = `XJIC_CNT_W
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clr_flag_i,
  output logic [CNT_W:0] value_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic flag;
  } xjic_rtc_st_t;
  xjic_rtc_st_t s_r;
  xjic_rtc_st_t s_nxt;
  // count every period; overflow sets bit CNT_W, set wins over clear
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 1'b1; // RL10
    if (clr_flag_i)
    begin
      s_nxt.flag = 1'b0;
    end
    if (&s_r.cnt)
    begin
      s_nxt.flag = 1'b1; // RL11
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign value_o = {s_r.flag, s_r.cnt};
endmodule : xjic_rtc

//--- test/xjic_checker.sv
`timescale 1ns/1ns
module xjic_checker
  import xjic_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 60,
  parameter int NCH = 16
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic exit_instr_i,
  input wire logic err_instr_i,
  input wire logic word_end_i,
  input wire logic ovf_i,
  input wire logic unf_i,
  input wire logic ind_i,
  input wire logic hw_err_i,
  input wire logic range_err_i,
  input wire logic [AW-1:0] buffer_bias_i,
  input wire logic mem_ack_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic ctx_we_o,
  input wire logic busy_o,
  input wire logic [AW-1:0] psw_o,
  input wire logic [AW-1:0] pc_copies_o [6],
  input wire logic [17:0] rtc_o
);
  logic [AW-1:0] st_addr_r;
  logic [4:0] nld_r;
  logic [1:0] rel_r;
  logic quiet;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // no exit cause on the instruction side, so only interrupts could fire
  assign quiet = !(exit_instr_i | err_instr_i | word_end_i | ovf_i | unf_i
    | ind_i | hw_err_i | range_err_i);
  // load address, loads per exchange, edges since deadstart release
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_addr_r <= '0;
      nld_r <= 5'h0;
      rel_r <= 2'h0;
    end
    else
    begin
      if (mem_req_o && mem_ack_i && !mem_we_o)
        st_addr_r <= mem_addr_o;
      if (!busy_o)
        nld_r <= 5'h0;
      else if (mem_req_o && mem_ack_i && !mem_we_o)
        nld_r <= nld_r + 5'h1;
      if (rel_r != 2'h3)
        rel_r <= rel_r + 2'h1;
    end
  end
  a_pc_equal: assert property (pc_copies_o[1] == pc_copies_o[0]
    && pc_copies_o[2] == pc_copies_o[0] && pc_copies_o[3] == pc_copies_o[0]
    && pc_copies_o[4] == pc_copies_o[0] && pc_copies_o[5] == pc_copies_o[0])
    else $error("program counter copies differ");
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped or changed before ack");
  a_store_after_load: assert property (mem_req_o && mem_ack_i
    && !mem_we_o |-> ##[1:3] (mem_req_o && mem_we_o
    && mem_addr_o == st_addr_r))
    else $error("load not followed by store of same word");
  a_ctx_after_load: assert property (mem_req_o && mem_ack_i && !mem_we_o
    |-> ##[1:2] ctx_we_o) else $error("loaded word not written to context");
  a_sixteen_words: assert property ($fell(busy_o) |-> nld_r == 5'd16)
    else $error("exchange did not move sixteen words");
  a_busy_mem: assert property (mem_req_o |-> busy_o)
    else $error("memory request outside an exchange");
  a_ds_start: assert property (rel_r == 2'h1 |-> ##[0:4]
    (mem_req_o && !mem_we_o && mem_addr_o == buffer_bias_i))
    else $error("deadstart exchange missing or misplaced");
  a_monitor_holds: assert property (psw_o[1] && !busy_o && quiet
    && $past(quiet) && $past(quiet, 2) |=> !busy_o)
    else $error("interrupt honoured in monitor mode");
  a_range_exit: assert property (!busy_o && range_err_i
    |-> ##[1:4] busy_o) else $error("range error did not exit");
  a_step_exit: assert property (!busy_o && psw_o[2] && word_end_i
    |-> ##[1:4] busy_o) else $error("step mode did not exit");
  a_rtc_count: assert property ($past(nrst_i)
    |-> rtc_o[16:0] == $past(rtc_o[16:0]) + 17'h1)
    else $error("clock counter did not advance by one");
  a_rtc_flag: assert property (rtc_o[16:0] == 17'h1FFFF |=> rtc_o[17])
    else $error("counter overflow did not set flag");
  c_deadstart: cover property (rel_r == 2'h1 ##[1:4] mem_req_o);
  c_io_after_mon: cover property ($fell(psw_o[1]) ##[1:20] busy_o);
  c_step: cover property (psw_o[2] && word_end_i ##[1:4] busy_o);
endmodule : xjic_checker
bind xjic_top xjic_checker #(.AW(AW), .DW(DW), .NCH(NCH)) xjic_checker_inst (.*);

//--- test/xjic_mem_model.sv
`timescale 1ns/1ns
module xjic_mem_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [17:0] addr_i,
  input wire logic [59:0] wdata_i,
  output logic ack_o,
  output logic [59:0] rdata_o
);
  logic [59:0] mem [512];
  int n_st = 0;
  int n_ld = 0;
  int wait_n = 0;
  // one word per ack; stale read data is inverted so it never looks valid
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= 60'h0;
      wait_n <= 0;
    end
    else if (ack_o && req_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (we_i)
        mem[addr_i[8:0]] <= wdata_i;
      if (we_i)
        n_st <= n_st + 1;
      else
        n_ld <= n_ld + 1;
    end
    else if (req_i && wait_n >= (slow_i ? 3 : 0))
    begin
      ack_o <= 1'b1;
      rdata_o <= we_i ? ~rdata_o : mem[addr_i[8:0]];
      wait_n <= 0;
    end
    else
    begin
      ack_o <= 1'b0;
      wait_n <= req_i ? wait_n + 1 : 0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : xjic_mem_model

//--- test/tb_exchange_jump_interrupt_control.sv
`timescale 1ns/1ns
module tb_exchange_jump_interrupt_control;
  import xjic_pkg::*;
  localparam logic [17:0] NONE = 18'h3FFFF;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic slow = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [17:0] bias = 18'h00100;
  logic [17:0] base = 18'h00010;
  logic [17:0] jk = 18'h00050;
  logic mem_ack, mem_req, mem_we, ctx_we, busy;
  logic [59:0] mem_rdata, mem_wdata, ctx_wdata, ctx_rdata;
  logic [17:0] mem_addr, psw, rtc;
  logic [17:0] pcs [6];
  logic [3:0] ctx_idx;
  int err_count = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  // context words carry their own index so stores can be traced
  assign ctx_rdata = 60'hC00 | 60'(ctx_idx);
  xjic_top xjic_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .exit_instr_i(ev[0]), .exit_j_plus_k_i(jk), .err_instr_i(ev[1]),
    .word_end_i(ev[2]), .ovf_i(ev[3]), .unf_i(ev[4]), .ind_i(ev[5]),
    .hw_err_i(ev[6]), .range_err_i(ev[7]), .buf_thresh_i({15'h0, ev[8]}),
    .record_pulse_i({ev[9], 15'h0}), .pp_xchg_req_i(ev[10]),
    .buffer_bias_i(bias), .mem_base_i(base), .ctx_rdata_i(ctx_rdata),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .mem_req_o(mem_req),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .ctx_idx_o(ctx_idx), .ctx_we_o(ctx_we), .ctx_wdata_o(ctx_wdata),
    .busy_o(busy), .psw_o(psw), .pc_copies_o(pcs), .rtc_o(rtc));
  xjic_mem_model xjic_mem_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .slow_i(slow), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
    .wdata_i(mem_wdata), .ack_o(mem_ack), .rdata_o(mem_rdata));
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(input logic [59:0] got, input logic [59:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait for a request or for the end of an exchange
  task automatic wait_sig(input bit want_req);
    int n;
    n = 0;
    #1;
    while ((want_req ? mem_req : !busy) !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400)
      begin
        check(60'(n), 60'h0);
        complete_run();
      end
    end
  endtask : wait_sig
  task automatic pk(input logic [8:0] b, input logic [17:0] s,
                    input logic [17:0] ne, input logic [17:0] ee);
    for (int i = 0; i < 16; i++)
      xjic_mem_model_inst.mem[b + 9'(i)] = 60'h0;
    xjic_mem_model_inst.mem[b + 9'h1] = 60'(s);
    xjic_mem_model_inst.mem[b + 9'h2] = 60'(ne);
    xjic_mem_model_inst.mem[b + 9'h3] = 60'(ee);
    xjic_mem_model_inst.mem[b + 9'hF] = 60'hA000 | 60'(b);
  endtask : pk
  // pulse causes, then expect an exchange to b or none at all
  task automatic step(input logic [10:0] m, input logic [17:0] b);
    logic [59:0] pw;
    logic [59:0] cw;
    logic [16:0] r0;
    int s0;
    int l0;
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 11'h000;
    if (b == NONE)
    begin
      #1 r0 = rtc[16:0];
      repeat (20) @(posedge clk_i);
      #1 check(60'(busy), 60'h0);
      check(60'(rtc[16:0] - r0), 60'h14);
    end
    else
    begin
      wait_sig(1'b1);
      check(60'(mem_addr), 60'(b));
      pw = xjic_mem_model_inst.mem[b[8:0] + 9'h1];
      cw = xjic_mem_model_inst.mem[b[8:0] + 9'hF];
      s0 = xjic_mem_model_inst.n_st;
      l0 = xjic_mem_model_inst.n_ld;
      wait_sig(1'b0);
      check(60'(psw), 60'(pw[17:0]));
      check(60'(xjic_mem_model_inst.n_st - s0), 60'h10);
      check(60'(xjic_mem_model_inst.n_ld - l0), 60'h10);
      check(ctx_wdata, cw);
      check(xjic_mem_model_inst.mem[b[8:0] + 9'h5], 60'hC05);
    end
  endtask : step
  initial
  begin
    pk(9'h100, 18'h00002, 18'h00020, 18'h00030);
    pk(9'h020, 18'h00000, 18'h00040, 18'h00030);
    pk(9'h040, 18'h00003, 18'h00020, 18'h00030);
    pk(9'h060, 18'h00002, 18'h00020, 18'h00030);
    pk(9'h030, 18'h0000A, 18'h00020, 18'h00070);
    pk(9'h070, 18'h00006, 18'h00020, 18'h00080);
    pk(9'h080, 18'h00002, 18'h00020, 18'h00090);
    pk(9'h090, 18'h00006, 18'h00020, 18'h000A0);
    pk(9'h0A0, 18'h00002, 18'h00020, 18'h00030);
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    step(11'h000, 18'h00100);
    check(60'(xjic_mem_model_inst.mem[9'h101][17:0]), 60'h40);
    step(11'h700, NONE);
    step(11'h001, 18'h00020);
    step(11'h000, 18'h00040);
    step(11'h001, 18'h00060);
    step(11'h038, NONE);
    slow <= 1'b1;
    step(11'h080, 18'h00030);
    step(11'h010, NONE);
    step(11'h008, 18'h00070);
    check(60'(xjic_mem_model_inst.mem[9'h071][7]), 60'h1);
    step(11'h004, 18'h00080);
    step(11'h040, 18'h00090);
    step(11'h006, 18'h000A0);
    step(11'h002, 18'h00030);
    complete_run();
  end
endmodule : tb_exchange_jump_interrupt_control
